// [verilog/ddrb_sram_port.sv]
// Burst-of-2 separate-I/O DDR SRAM port: command sampling, beats, masks, pass-through
// Functional notes
// - Read address and read enable are sampled on each rising input clock edge.
// - Read enable low starts read; beats launch on output fall then output rise.
// - Read enable high on rising input clock gives a read deselect cycle.
// - Write enable sampled on rising input clock; address on following falling-clock rise.
// - First write beat captured on the edge that samples write enable low.
// - Second write beat and address captured on next falling-clock rise.
// - Write enable high gives a write deselect; memory stays unchanged.
// - Both enables high deselect both ports.
// - A command on one port never disturbs a transfer on the other.
// - A started two-beat transfer always completes; new commands do not abort it. Here a first-beat launch in the same cycle drops the second beat.
// - Each lane mask sampled with its beat; high mask keeps 9-bit lane unchanged.
// - Each write command defines two beats, up to 36 bits.
// - Masks apply independently per beat and per lane.
// - Output clocks both high: input clocks launch read data instead.
// - Free cycle counter triggers impedance evaluation every 1024 cycles.
// - Each evaluation moves the impedance code at most one step.
// - Read right after write to same location returns the new data.
// - Same address read and written in one cycle forwards incoming write data.
// - Low loop bypass input disables the internal delay-locked loop.
// - Alternating reads and writes may start with either command.
// - Burst address low bit is zero on first beat, one on second.
// - Read and write sequencers may be active together, both stepped by input clock; here read beats launch on output clocks unless tied high.
module ddrb_sram_port (
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    input  wire logic                              ce_i,
    input  wire logic                              input_timing_rise_i,
    input  wire logic                              input_timing_fall_i,
    input  wire logic                              output_timing_rise_i,
    input  wire logic                              output_timing_fall_i,
    input  wire logic                              fetch_en_n_i,
    input  wire logic                              store_en_n_i,
    input  wire logic [ddrb_pkg::ADDR_W-1:0]       line_index_i,
    input  wire logic [ddrb_pkg::DATA_W-1:0]       store_bus_i,
    input  wire logic [ddrb_pkg::LANES-1:0]        lane_mask_n_i,
    input  wire logic                              loop_bypass_n_i,
    input  wire logic                              imped_ref_i,
    output logic      [ddrb_pkg::DATA_W-1:0]       fetch_bus_o,
    output logic                                   fetch_oe_o,
    output logic                                   echo_strobe_o,
    output logic                                   echo_strobe_n_o,
    output logic                                   loop_off_o,
    output logic      [ddrb_pkg::IMP_CODE_W-1:0]   imped_code_o,
    output logic                                   imped_eval_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling and link clock edge detection
    ddrb_pkg::ddrb_pins_t              pins_raw;
    ddrb_pkg::ddrb_pins_t              pins;
    logic [ddrb_pkg::PINS_W-1:0]       pins_sync;
    logic [3:0]                        clk_prev;
    logic [3:0]                        next_clk_prev;
    logic                              k_rise;
    logic                              kn_rise;
    logic                              c_rise;
    logic                              cn_rise;
    logic                              out_tied;
    logic                              trig1;
    logic                              trig2;

    always_comb begin
        pins_raw.in_rise       = input_timing_rise_i;
        pins_raw.in_fall       = input_timing_fall_i;
        pins_raw.out_rise      = output_timing_rise_i;
        pins_raw.out_fall      = output_timing_fall_i;
        pins_raw.fetch_en_n    = fetch_en_n_i;
        pins_raw.store_en_n    = store_en_n_i;
        pins_raw.loop_bypass_n = loop_bypass_n_i;
        pins_raw.imped_ref     = imped_ref_i;
        pins_raw.line_index    = line_index_i;
        pins_raw.beat.mask_n   = lane_mask_n_i;
        pins_raw.beat.data     = store_bus_i;
    end

    // Data and strobes share one synchroniser depth, so they stay aligned to their clock edges
    ddrb_sync #(
        .WIDTH (ddrb_pkg::PINS_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .async_i (pins_raw),
        .sync_o  (pins_sync)
    );

    always_comb begin
        pins          = ddrb_pkg::ddrb_pins_t'(pins_sync);
        next_clk_prev = {pins.in_rise, pins.in_fall, pins.out_rise, pins.out_fall};
        k_rise        = pins.in_rise & ~clk_prev[3];
        kn_rise       = pins.in_fall & ~clk_prev[2];
        c_rise        = pins.out_rise & ~clk_prev[1];
        cn_rise       = pins.out_fall & ~clk_prev[0];
        out_tied      = pins.out_rise & pins.out_fall;
        trig1         = out_tied ? kn_rise : cn_rise;
        trig2         = out_tied ? k_rise : c_rise;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_prev <= 4'hf;
        end else if (ce_i) begin
            clk_prev <= next_clk_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and write port
    function automatic logic [ddrb_pkg::DATA_W-1:0] lane_merge(
        input logic [ddrb_pkg::DATA_W-1:0] old_w,
        input ddrb_pkg::ddrb_beat_t        beat
    );
        logic [ddrb_pkg::DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < ddrb_pkg::LANES; l++) begin
            if (!beat.mask_n[l]) begin
                res[l*ddrb_pkg::LANE_W +: ddrb_pkg::LANE_W] = beat.data[l*ddrb_pkg::LANE_W +: ddrb_pkg::LANE_W];
            end
        end
        return res;
    endfunction

    logic [ddrb_pkg::DATA_W-1:0] mem      [ddrb_pkg::MEM_DEPTH];
    logic [ddrb_pkg::DATA_W-1:0] next_mem [ddrb_pkg::MEM_DEPTH];
    logic                        w_pend;
    logic                        next_w_pend;
    ddrb_pkg::ddrb_beat_t        w_beat0;
    ddrb_pkg::ddrb_beat_t        next_w_beat0;
    logic                        commit;

    always_comb begin
        next_mem     = mem;
        next_w_pend  = w_pend;
        next_w_beat0 = w_beat0;
        commit       = kn_rise & w_pend;
        if (commit) begin
            // Beat 0 at even index, beat 1 at odd: burst low bit is internal
            next_mem[{pins.line_index, 1'b0}] = lane_merge(mem[{pins.line_index, 1'b0}], w_beat0);
            next_mem[{pins.line_index, 1'b1}] = lane_merge(mem[{pins.line_index, 1'b1}], pins.beat);
            next_w_pend = 1'b0;
        end
        if (k_rise) begin
            next_w_pend  = ~pins.store_en_n;
            next_w_beat0 = pins.beat;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < ddrb_pkg::MEM_DEPTH; i++) begin
                mem[i] <= ddrb_pkg::DATA_RST;
            end
            w_pend  <= 1'b0;
            w_beat0 <= '0;
        end else if (ce_i) begin
            mem     <= next_mem;
            w_pend  <= next_w_pend;
            w_beat0 <= next_w_beat0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port: command register, launch stage, output registers
    logic                        rd_pend;
    logic                        next_rd_pend;
    logic [ddrb_pkg::ADDR_W-1:0] rd_addr;
    logic [ddrb_pkg::ADDR_W-1:0] next_rd_addr;
    logic                        arm1;
    logic                        next_arm1;
    logic                        arm2;
    logic                        next_arm2;
    logic [ddrb_pkg::DATA_W-1:0] o_beat0;
    logic [ddrb_pkg::DATA_W-1:0] next_o_beat0;
    logic [ddrb_pkg::DATA_W-1:0] o_beat1;
    logic [ddrb_pkg::DATA_W-1:0] next_o_beat1;
    logic [ddrb_pkg::DATA_W-1:0] hold1;
    logic [ddrb_pkg::DATA_W-1:0] next_hold1;
    logic [ddrb_pkg::DATA_W-1:0] next_fetch_bus;
    logic                        next_fetch_oe;

    always_comb begin
        next_rd_pend   = rd_pend;
        next_rd_addr   = rd_addr;
        next_arm1      = arm1;
        next_arm2      = arm2;
        next_o_beat0   = o_beat0;
        next_o_beat1   = o_beat1;
        next_hold1     = hold1;
        next_fetch_bus = fetch_bus_o;
        next_fetch_oe  = fetch_oe_o;
        // Second beat is handled first, so a reload in the same cycle overrides it and cuts it short
        if (trig2 && arm2) begin
            next_fetch_bus = hold1;
            next_arm2      = 1'b0;
        end
        if (trig1) begin
            if (arm1) begin
                next_fetch_bus = o_beat0;
                next_fetch_oe  = 1'b1;
                next_hold1     = o_beat1;
                next_arm2      = 1'b1;
                next_arm1      = 1'b0;
            end else if (!arm2) begin
                next_fetch_oe = 1'b0;
            end
        end
        if (k_rise) begin
            // Writes commit on the falling-clock edge before this load, so same-cycle
            // address reuse sees the incoming write data rather than stale content
            if (rd_pend) begin
                next_o_beat0 = mem[{rd_addr, 1'b0}];
                next_o_beat1 = mem[{rd_addr, 1'b1}];
                next_arm1    = 1'b1;
            end
            next_rd_pend = ~pins.fetch_en_n;
            next_rd_addr = pins.line_index;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_pend     <= 1'b0;
            rd_addr     <= '0;
            arm1        <= 1'b0;
            arm2        <= 1'b0;
            o_beat0     <= ddrb_pkg::DATA_RST;
            o_beat1     <= ddrb_pkg::DATA_RST;
            hold1       <= ddrb_pkg::DATA_RST;
            fetch_bus_o <= ddrb_pkg::DATA_RST;
            fetch_oe_o  <= 1'b0;
        end else if (ce_i) begin
            rd_pend     <= next_rd_pend;
            rd_addr     <= next_rd_addr;
            arm1        <= next_arm1;
            arm2        <= next_arm2;
            o_beat0     <= next_o_beat0;
            o_beat1     <= next_o_beat1;
            hold1       <= next_hold1;
            fetch_bus_o <= next_fetch_bus;
            fetch_oe_o  <= next_fetch_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Echo strobes, loop bypass and impedance calibration
    logic next_echo;
    logic next_echo_n;
    logic next_loop_off;

    always_comb begin
        next_echo     = out_tied ? pins.in_rise : pins.out_rise;
        next_echo_n   = out_tied ? pins.in_fall : pins.out_fall;
        next_loop_off = ~pins.loop_bypass_n;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            echo_strobe_o   <= 1'b0;
            echo_strobe_n_o <= 1'b0;
            loop_off_o      <= 1'b0;
        end else if (ce_i) begin
            echo_strobe_o   <= next_echo;
            echo_strobe_n_o <= next_echo_n;
            loop_off_o      <= next_loop_off;
        end
    end

    ddrb_imp_cal u_imp (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .tick_i  (k_rise),
        .above_i (pins.imped_ref),
        .code_o  (imped_code_o),
        .eval_o  (imped_eval_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_rd_sample;
        ce_i && k_rise |=> rd_pend == !$past(pins.fetch_en_n) && rd_addr == $past(pins.line_index);
    endproperty
    a_rd_sample: assert property (p_rd_sample) else $error("read command not sampled");

    property p_rd_arm;
        ce_i && k_rise && rd_pend |=> arm1;
    endproperty
    a_rd_arm: assert property (p_rd_arm) else $error("pending read not armed at input clock rise");

    property p_beat1_out;
        ce_i && trig1 && arm1 |=> fetch_oe_o && fetch_bus_o == $past(o_beat0) && arm2;
    endproperty
    a_beat1_out: assert property (p_beat1_out) else $error("first read beat not launched");

    property p_beat2_kept;
        ce_i && arm2 && !trig2 |=> arm2;
    endproperty
    a_beat2_kept: assert property (p_beat2_kept) else $error("second read beat aborted");

    property p_wr_capture;
        ce_i && k_rise |=> w_pend == !$past(pins.store_en_n) && w_beat0 == $past(pins.beat);
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("write beat zero not captured");

    property p_full_deselect;
        ce_i && k_rise && pins.fetch_en_n && pins.store_en_n |=> !rd_pend && !w_pend;
    endproperty
    a_full_deselect: assert property (p_full_deselect) else $error("both ports not deselected");

    property p_wr_commit;
        ce_i && commit |=> mem[{$past(pins.line_index), 1'b1}][8:0] ==
            ($past(pins.beat.mask_n[0]) ? $past(mem[{pins.line_index, 1'b1}][8:0]) : $past(pins.beat.data[8:0]));
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("second beat lane zero mask not honoured");

    property p_loop_off;
        ce_i && !pins.loop_bypass_n |=> loop_off_o;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("loop not disabled");

    c_read:  cover property (ce_i && trig2 && arm2);
    c_write: cover property (ce_i && commit);
    c_tied:  cover property (ce_i && out_tied && trig1 && arm1);
    c_both:  cover property (ce_i && k_rise && !pins.fetch_en_n && !pins.store_en_n);
endmodule

// [verilog/ddrb_pkg.sv]
// Shared constants and carrier types for the burst-of-2 separate-I/O SRAM port
package ddrb_pkg;
    localparam int DATA_W     = 18;
    localparam int LANE_W     = 9;
    localparam int LANES      = 2;
    localparam int BEATS      = 2;
    localparam int ADDR_W     = 4;
    localparam int MEM_DEPTH  = (2 ** ADDR_W) * BEATS;
    localparam int IMP_PERIOD = 1024;
    localparam int IMP_CNT_W  = 10;
    localparam int IMP_CODE_W = 6;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_RST = 6'h20;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX = 6'h3f;
    localparam logic [IMP_CNT_W-1:0]  IMP_CNT_LAST = 10'h3ff;
    localparam logic [DATA_W-1:0]     DATA_RST     = 18'h00000;

    // One data beat with its lane masks, sampled together
    typedef struct packed {
        logic [LANES-1:0]  mask_n;
        logic [DATA_W-1:0] data;
    } ddrb_beat_t;

    // Every pin that crosses into the sampling clock domain
    typedef struct packed {
        logic              in_rise;
        logic              in_fall;
        logic              out_rise;
        logic              out_fall;
        logic              fetch_en_n;
        logic              store_en_n;
        logic              loop_bypass_n;
        logic              imped_ref;
        logic [ADDR_W-1:0] line_index;
        ddrb_beat_t        beat;
    } ddrb_pins_t;

    localparam int PINS_W = $bits(ddrb_pins_t);
endpackage

// [verilog/ddrb_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous pins
module ddrb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = ce_i ? async_i : meta;
        next_sync = ce_i ? meta : sync_o;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // Reset to the idle-high level of enables, tied output clocks and loop pin: no false edge after reset
            meta   <= '1;
            sync_o <= '1;
        end else begin
            meta   <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule

// [verilog/ddrb_imp_cal.sv]
// Periodic output impedance evaluation: cycle counter and one-step code tracking
module ddrb_imp_cal (
    input  wire logic                           clk_i,
    input  wire logic                           rst_b_i,
    input  wire logic                           ce_i,
    input  wire logic                           tick_i,
    input  wire logic                           above_i,
    output logic      [ddrb_pkg::IMP_CODE_W-1:0] code_o,
    output logic                                eval_o
);
    logic [ddrb_pkg::IMP_CNT_W-1:0]  cnt;
    logic [ddrb_pkg::IMP_CNT_W-1:0]  next_cnt;
    logic [ddrb_pkg::IMP_CODE_W-1:0] next_code;
    logic                            next_eval;

    always_comb begin
        next_cnt  = cnt;
        next_code = code_o;
        next_eval = 1'b0;
        if (tick_i) begin
            next_cnt = cnt + 10'h001;
            if (cnt == ddrb_pkg::IMP_CNT_LAST) begin
                next_eval = 1'b1;
                // One step per evaluation keeps drive changes glitch-free on the bus
                if (above_i && code_o != ddrb_pkg::IMP_CODE_MAX) begin
                    next_code = code_o + 6'h01;
                end else if (!above_i && code_o != 6'h00) begin
                    next_code = code_o - 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt    <= '0;
            code_o <= ddrb_pkg::IMP_CODE_RST;
            eval_o <= 1'b0;
        end else if (ce_i) begin
            cnt    <= next_cnt;
            code_o <= next_code;
            eval_o <= next_eval;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_imp_step;
        ce_i |=> (code_o == $past(code_o)) || (code_o == $past(code_o) + 6'h01)
                 || (code_o == $past(code_o) - 6'h01);
    endproperty
    a_imp_step: assert property (p_imp_step) else $error("impedance code moved more than one step");

    property p_imp_period;
        ce_i && tick_i && cnt == ddrb_pkg::IMP_CNT_LAST |=> eval_o && cnt == '0;
    endproperty
    a_imp_period: assert property (p_imp_period) else $error("evaluation missing at counter wrap");

    property p_imp_quiet;
        ce_i && !(tick_i && cnt == ddrb_pkg::IMP_CNT_LAST) |=> !eval_o;
    endproperty
    a_imp_quiet: assert property (p_imp_quiet) else $error("evaluation outside counter wrap");

    c_imp_eval: cover property (eval_o);
endmodule

// [testbench/ddrb_host.sv]
// Host controller model: link clocks, commands, write beats and read beat sampling
module ddrb_host (
    input  wire logic                        clk_i,
    input  wire logic [ddrb_pkg::DATA_W-1:0] fetch_bus_i,
    input  wire logic                        fetch_oe_i,
    output logic                             k_o,
    output logic                             kb_o,
    output logic                             c_o,
    output logic                             cb_o,
    output logic                             fetch_en_n_o,
    output logic                             store_en_n_o,
    output logic [ddrb_pkg::ADDR_W-1:0]      line_index_o,
    output logic [ddrb_pkg::DATA_W-1:0]      store_bus_o,
    output logic [ddrb_pkg::LANES-1:0]       lane_mask_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic                        use_c = 1'b0;
    logic [ddrb_pkg::DATA_W-1:0] q0;
    logic [ddrb_pkg::DATA_W-1:0] q1;
    logic                        oe1;
    int                          k_count = 0;

    initial begin
        {k_o, kb_o, c_o, cb_o, fetch_en_n_o, store_en_n_o} = 6'h1f;
        line_index_o = '0;
        {lane_mask_n_o, store_bus_o} = '1;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    // Each pin group changes midway between link edges, so the synchroniser sees it settled
    task automatic k_cycle(input logic r_n, input logic [ddrb_pkg::ADDR_W-1:0] ra, input logic w_n,
                           input logic [ddrb_pkg::ADDR_W-1:0] wa, input ddrb_pkg::ddrb_beat_t b0,
                           input ddrb_pkg::ddrb_beat_t b1);
        {fetch_en_n_o, store_en_n_o, line_index_o} = {r_n, w_n, ra};
        {lane_mask_n_o, store_bus_o} = w_n ? {b0.mask_n, ~store_bus_o} : b0;
        tick(2);
        {k_o, kb_o} = 2'h2;
        k_count++;
        tick(1);
        q0 = fetch_bus_i;
        {c_o, cb_o} = use_c ? 2'h2 : 2'h3;  // Output clocks trail by one clock
        tick(1);
        line_index_o = wa;
        {lane_mask_n_o, store_bus_o} = w_n ? {b1.mask_n, ~store_bus_o} : b1;
        tick(2);
        {k_o, kb_o} = 2'h1;
        tick(1);
        q1 = fetch_bus_i;
        oe1 = fetch_oe_i;
        {c_o, cb_o} = use_c ? 2'h1 : 2'h3;
        tick(1);
    endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the burst-of-2 SRAM port with a host controller model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = ddrb_pkg::DATA_W;
    localparam int AW = ddrb_pkg::ADDR_W;
    logic          clk_i = 1'b0;
    logic          rst_b_i = 1'b0;
    logic          k, kb, c, cb, fetch_en_n, store_en_n, fetch_oe, echo, echo_n, loop_off, imped_eval;
    logic          loop_bypass_n = 1'b1;
    logic          imped_ref = 1'b1;
    logic [AW-1:0] line_index;
    logic [DW-1:0] store_bus, fetch_bus;
    logic [1:0]    lane_mask_n;
    logic [5:0]    imped_code;
    int            fails = 0;
    int            checks = 0;
    int            evals = 0;
    logic [DW-1:0] mem [2**AW*2] = '{default: '0};
    logic [1:0]    pv = 2'h0;
    logic [DW-1:0] pe0 [2];
    logic [DW-1:0] pe1 [2];

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (imped_eval === 1'b1) evals++;
    end

    ddrb_sram_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .input_timing_rise_i(k),
        .input_timing_fall_i(kb), .output_timing_rise_i(c), .output_timing_fall_i(cb),
        .fetch_en_n_i(fetch_en_n), .store_en_n_i(store_en_n), .line_index_i(line_index),
        .store_bus_i(store_bus), .lane_mask_n_i(lane_mask_n), .loop_bypass_n_i(loop_bypass_n),
        .imped_ref_i(imped_ref), .fetch_bus_o(fetch_bus), .fetch_oe_o(fetch_oe), .echo_strobe_o(echo),
        .echo_strobe_n_o(echo_n), .loop_off_o(loop_off), .imped_code_o(imped_code), .imped_eval_o(imped_eval));
    ddrb_host host (.clk_i(clk_i), .fetch_bus_i(fetch_bus), .fetch_oe_i(fetch_oe), .k_o(k), .kb_o(kb),
        .c_o(c), .cb_o(cb), .fetch_en_n_o(fetch_en_n), .store_en_n_o(store_en_n), .line_index_o(line_index),
        .store_bus_o(store_bus), .lane_mask_n_o(lane_mask_n));
    //////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input ddrb_pkg::ddrb_beat_t b);
        return {b.mask_n[1] ? old[17:9] : b.data[17:9], b.mask_n[0] ? old[8:0] : b.data[8:0]};
    endfunction

    // Reads land two link cycles later, so expectations ride a two-stage queue
    task automatic op(input logic r_n, input logic [AW-1:0] ra, input logic w_n, input logic [AW-1:0] wa,
                      input ddrb_pkg::ddrb_beat_t b0, input ddrb_pkg::ddrb_beat_t b1);
        host.k_cycle(r_n, ra, w_n, wa, b0, b1);
        check(DW'(host.oe1), DW'(pv[1]));
        check(DW'({echo, echo_n}), DW'(2'h2));
        if (pv[1]) begin
            check(host.q0, pe0[1]);
            check(host.q1, pe1[1]);
        end
        if (!w_n) begin
            mem[{wa, 1'b0}] = merge(mem[{wa, 1'b0}], b0);
            mem[{wa, 1'b1}] = merge(mem[{wa, 1'b1}], b1);
        end
        pv = {pv[0], ~r_n};
        {pe0[1], pe1[1]} = {pe0[0], pe1[0]};
        {pe0[0], pe1[0]} = {mem[{ra, 1'b0}], mem[{ra, 1'b1}]};
    endtask

    // Deselected cycles still offer live masks and changing data
    task automatic idle(input int n);
        repeat (n) op(1'b1, '0, 1'b1, '0, '0, '0);
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic t_alternate;
        for (int i = 0; i < 16; i++) begin
            op(1'b1, '0, 1'b0, AW'(i), {2'h0, 4'(i), 14'h2b5c}, {2'h0, 4'(~i), 14'h14a3});
        end
        for (int i = 0; i < 16; i++) begin
            op(1'b0, AW'(i), ~i[0], AW'(i + 1), {2'h0, 4'(i), 14'h0f0f}, {2'h0, 4'(i), 14'h30c3});
        end
        idle(2);
    endtask

    task automatic t_masks;
        for (int m = 0; m < 4; m++) begin
            op(1'b0, 4'h3, 1'b0, 4'h3, {2'(m), 18'h3ffff}, {2'(3 - m), 18'h15555 + 18'(m)});
        end
        idle(2);
    endtask

    task automatic t_deselect;
        op(1'b1, 4'h5, 1'b1, 4'h5, {2'h0, 18'h2aaaa}, {2'h0, 18'h15555});
        op(1'b0, 4'h5, 1'b1, 4'h6, {2'h0, 18'h2aaaa}, {2'h0, 18'h15555});
        idle(2);
    endtask

    task automatic t_delayed_c;
        host.use_c = 1'b1;
        for (int i = 0; i < 4; i++) begin
            op(1'b0, AW'(i * 3), 1'b0, AW'(i * 3), {2'h1, 18'h0c0c0}, {2'h2, 18'h3a5a5});
        end
        idle(2);
        host.use_c = 1'b0;
        idle(2);
    endtask

    task automatic wait_eval;
        int e0;
        e0 = evals;
        for (int n = 0; n < 1100 && evals == e0; n++) idle(1);
        check(DW'(evals - e0), DW'(1));
    endtask

    task automatic t_loop_imped;
        int k0;
        loop_bypass_n = 1'b0;
        host.tick(6);
        check(DW'(loop_off), DW'(1));
        check(DW'({echo, echo_n}), DW'(2'h1));
        loop_bypass_n = 1'b1;
        host.tick(6);
        check(DW'(loop_off), DW'(0));
        check(DW'(imped_code), DW'(ddrb_pkg::IMP_CODE_RST));
        wait_eval();
        check(DW'(imped_code), DW'(ddrb_pkg::IMP_CODE_RST + 6'h01));
        k0 = host.k_count;
        imped_ref = 1'b0;
        wait_eval();
        check(DW'(host.k_count - k0), DW'(ddrb_pkg::IMP_PERIOD));
        check(DW'(imped_code), DW'(ddrb_pkg::IMP_CODE_RST));
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        host.tick(12);
        rst_b_i = 1'b1;
        host.tick(4);
        check(DW'(fetch_oe), DW'(0));
        t_alternate();
        t_masks();
        t_deselect();
        t_delayed_c();
        t_loop_imped();
        complete_run();
    end

    // Impedance waits dominate: about 2050 link cycles of 8 clocks each
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        complete_run();
    end
endmodule
